// *** shared/gccb_pkg.sv ***
package gccb_pkg;

  // ----------------------------------------------------------------
  // Structure
  // ----------------------------------------------------------------
  localparam int unsigned NUM_BLOCKS_MAX = 20; // see RL1
  localparam int unsigned BLOCKS_PER_SIDE = 5; // see RL14
  localparam int unsigned PLL_OUTPUTS = 5; // see RL15
  localparam int unsigned PLL_PICK_W = 3;
  localparam int unsigned CLK_PINS = 2;
  localparam int unsigned CORNER_PINS = 2;

  // ----------------------------------------------------------------
  // Dynamic select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_PIN0 = 2'h0;
  localparam logic [1:0] SEL_PIN1 = 2'h1;
  localparam logic [1:0] SEL_PLL_A = 2'h2;
  localparam logic [1:0] SEL_PLL_B = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_DYNAMIC,
    SRC_DUAL_PURPOSE,
    SRC_CORNER,
    SRC_INTERNAL
  } gccb_static_src_e;

  typedef struct packed {
    logic [CLK_PINS-1:0] clk_pin;
    logic [PLL_OUTPUTS-1:0] pll_count;
    logic dual_pin;
    logic [CORNER_PINS-1:0] corner_pin;
  } gccb_pins_s;

  typedef struct packed {
    logic power_down;
    gccb_static_src_e static_src;
    logic corner_pick;
    logic [PLL_PICK_W-1:0] pll_pick_a;
    logic [PLL_PICK_W-1:0] pll_pick_b;
    logic out_zero_path;
    logic clkswitch;
  } gccb_cfg_s;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam gccb_pins_s PINS_RESET = gccb_pins_s'(10'h000);
  localparam gccb_cfg_s CFG_RESET = '{
    power_down: 1'b1,
    static_src: SRC_DYNAMIC,
    corner_pick: 1'b0,
    pll_pick_a: 3'h0,
    pll_pick_b: 3'h1,
    out_zero_path: 1'b0,
    clkswitch: 1'b0
  };

endpackage

// *** logic/gccb_clock_ctrl.sv ***
// Operation
// RL1: One block per global network, at most 20; only its output drives that net.
// RL2: Six candidates: two clock pins, two PLL outputs, one dual-purpose pin, internal.
// RL3: Two-bit user select picks among the two clock pins and two PLL outputs.
// RL4: Internal and dual-purpose sources are fixed by configuration, never at run time.
// RL5: PLL reference use allowed only when sources are PLL outputs or clock pins.
// RL6: Blocks fed by dual-purpose pins or internal logic never feed a PLL reference.
// RL7: User enable turns the global network on or off at run time.
// RL8: Disabled network gives its loads no edges; gating acts on the network only.
// RL9: Static power-down configuration keeps an unused network without any clock.
// RL10: Enable captured on the falling edge of the incoming clock.
// RL11: PLL output zero to clock pin path uses two cascaded enable registers.
// RL12: Gating never touches PLL feedback; PLL stays locked whatever the enable.
// RL13: Re-enabled network resumes at once, no relock or resynchronisation wait.
// RL14: Five control blocks per device side, next to that side's clock pins.
// RL15: Each PLL makes five outputs; only two reach the network through this block.
// RL16: Only one corner dual-purpose pin per corner feeds the block at a time.
// RL17: PLL input mux picks reference by switch from configuration or manual control.
// RL18: User disables, changes select, waits some new-source cycles, then re-enables.
// RL19: Disabled network held low; no partial pulses when gating or ungating.
`timescale 1ns/1ps
module gccb_clock_ctrl (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Candidate sources
  input wire gccb_pkg::gccb_pins_s i_pins,
  input wire logic i_internal_logic,
  // Configuration
  input wire gccb_pkg::gccb_cfg_s i_cfg,
  // User mode control
  input wire logic [1:0] i_clk_select,
  input wire logic i_net_enable,
  input wire logic i_manual_switch_en,
  input wire logic i_manual_switch,
  // Network and status
  output logic o_global_clock_net,
  output logic o_net_active,
  output logic o_pll_ref_allowed,
  output logic o_pll_reference,
  output logic o_cfg_loaded
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic pick_pll(input logic [gccb_pkg::PLL_OUTPUTS-1:0] v,
                                    input logic [gccb_pkg::PLL_PICK_W-1:0] idx);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < gccb_pkg::PLL_OUTPUTS; i++) begin
      if (int'(idx) == i) begin
        hit = v[i];
      end
    end
    return hit;
  endfunction

  function automatic logic [9:0] agree(input logic [9:0] s2, input logic [9:0] s3,
                                       input logic [9:0] held);
    return (s2 & s3) | (held & (s2 ^ s3));
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  gccb_pkg::gccb_pins_s sync1;
  gccb_pkg::gccb_pins_s sync2;
  gccb_pkg::gccb_pins_s sync3;
  gccb_pkg::gccb_pins_s flt;
  gccb_pkg::gccb_pins_s next_flt;

  assign next_flt = gccb_pkg::gccb_pins_s'(agree(sync2, sync3, flt));

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1 <= gccb_pkg::PINS_RESET;
      sync2 <= gccb_pkg::PINS_RESET;
      sync3 <= gccb_pkg::PINS_RESET;
      flt <= gccb_pkg::PINS_RESET;
    end else begin
      sync1 <= i_pins;
      sync2 <= sync1;
      sync3 <= sync2;
      flt <= next_flt;
    end
  end

  // ----------------------------------------------------------------
  // Configuration capture
  // ----------------------------------------------------------------
  gccb_pkg::gccb_cfg_s cfg_q;
  logic cfg_loaded;

  // Loaded once after reset release, frozen afterwards
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_q <= gccb_pkg::CFG_RESET;
      cfg_loaded <= 1'b0;
    end else if (!cfg_loaded) begin
      cfg_q <= i_cfg; // see RL4
      cfg_loaded <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  logic pll_a;
  logic pll_b;
  logic dyn_src;
  logic corner_lvl;
  logic src_sel;
  logic pd_eff;
  logic is_dynamic;

  assign pll_a = pick_pll(flt.pll_count, cfg_q.pll_pick_a); // see RL15
  assign pll_b = pick_pll(flt.pll_count, cfg_q.pll_pick_b); // see RL15
  assign dyn_src = (i_clk_select == gccb_pkg::SEL_PIN0) ? flt.clk_pin[0] :
                   (i_clk_select == gccb_pkg::SEL_PIN1) ? flt.clk_pin[1] :
                   (i_clk_select == gccb_pkg::SEL_PLL_A) ? pll_a : pll_b; // see RL3
  assign corner_lvl = flt.corner_pin[cfg_q.corner_pick]; // see RL16
  assign is_dynamic = (cfg_q.static_src == gccb_pkg::SRC_DYNAMIC);
  assign src_sel = is_dynamic ? dyn_src :
                   (cfg_q.static_src == gccb_pkg::SRC_DUAL_PURPOSE) ? flt.dual_pin :
                   (cfg_q.static_src == gccb_pkg::SRC_CORNER) ? corner_lvl :
                   i_internal_logic; // see RL2
  assign pd_eff = cfg_q.power_down | ~cfg_loaded; // see RL9

  // ----------------------------------------------------------------
  // Enable capture and gating
  // ----------------------------------------------------------------
  logic src_prev;
  logic src_fall;
  logic en_q1;
  logic en_q2;
  logic en_eff;
  logic next_net;

  assign src_fall = src_prev & ~src_sel;
  assign en_eff = cfg_q.out_zero_path ? en_q2 : en_q1; // see RL11
  // Enable moves only while the source is low, so pulses stay whole
  assign next_net = src_sel & en_eff & ~pd_eff; // see RL8 see RL19

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      src_prev <= 1'b0;
      en_q1 <= 1'b0;
      en_q2 <= 1'b0;
    end else begin
      src_prev <= src_sel;
      if (src_fall) begin
        en_q1 <= i_net_enable; // see RL7 see RL10
        en_q2 <= en_q1; // see RL11
      end
    end
  end

  // ----------------------------------------------------------------
  // PLL reference mux, untouched by the enable
  // ----------------------------------------------------------------
  logic switch_sel;
  logic next_ref;

  assign switch_sel = i_manual_switch_en ? i_manual_switch : cfg_q.clkswitch; // see RL17
  assign next_ref = switch_sel ? flt.clk_pin[1] : flt.clk_pin[0]; // see RL12

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_global_clock_net <= 1'b0;
      o_net_active <= 1'b0;
      o_pll_ref_allowed <= 1'b0;
      o_pll_reference <= 1'b0;
      o_cfg_loaded <= 1'b0;
    end else begin
      o_global_clock_net <= next_net; // see RL1 see RL13
      o_net_active <= en_eff & ~pd_eff;
      o_pll_ref_allowed <= cfg_loaded & is_dynamic; // see RL5 see RL6
      o_pll_reference <= next_ref;
      o_cfg_loaded <= cfg_loaded;
    end
  end

  // ----------------------------------------------------------------
  // Gated-off run length, for coverage of long sleeps
  // ----------------------------------------------------------------
  logic [7:0] off_cnt;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      off_cnt <= 8'h00;
    end else if (o_net_active) begin
      off_cnt <= 8'h00;
    end else if (off_cnt != 8'hff) begin
      off_cnt <= off_cnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  net_rise_cause_a: assert property ( // see RL8
    $rose(o_global_clock_net) |-> $past(src_sel) && $past(en_eff) && !$past(pd_eff))
    else $error("Network rose without source and enable");

  en_fall_edge_a: assert property ( // see RL10
    $changed(en_q1) |-> $past(src_fall))
    else $error("Enable moved outside a falling edge");

  two_stage_en_a: assert property ( // see RL11
    $changed(en_q2) |-> $past(src_fall) && (en_q2 == $past(en_q1)))
    else $error("Second enable stage not cascaded");

  power_down_a: assert property ( // see RL9
    cfg_q.power_down |=> !o_global_clock_net && !o_net_active)
    else $error("Powered-down network carries a clock");

  cfg_frozen_a: assert property ( // see RL4
    cfg_loaded |=> $stable(cfg_q) && cfg_loaded)
    else $error("Static configuration changed at run time");

  ref_forbidden_a: assert property ( // see RL6
    (cfg_loaded && !is_dynamic) |=> !o_pll_ref_allowed)
    else $error("Static source block offered as PLL reference");

  ref_allowed_a: assert property ( // see RL5
    o_pll_ref_allowed |-> $past(cfg_loaded) && $past(is_dynamic))
    else $error("PLL reference allowed for a wrong source");

  ref_mux_a: assert property ( // see RL17
    1'b1 |=> o_pll_reference == ($past(switch_sel) ? $past(flt.clk_pin[1]) :
                                 $past(flt.clk_pin[0])))
    else $error("PLL reference mux picked the wrong pin");

  resume_now_a: assert property ( // see RL13
    (en_eff && !pd_eff && src_sel) |=> o_global_clock_net)
    else $error("Enabled network missed a source pulse");

  no_partial_a: assert property ( // see RL19
    $fell(o_global_clock_net) |-> !$past(src_sel) || $past(pd_eff))
    else $error("Network pulse cut short");

  gate_low_a: assert property ( // see RL8
    !o_net_active |-> !o_global_clock_net)
    else $error("Inactive network still clocks");

  act_track_a: assert property ( // see RL7
    1'b1 |=> o_net_active == $past(en_eff && !pd_eff))
    else $error("Active flag does not follow the enable");

  cfg_flag_a: assert property ( // see RL4
    1'b1 |=> o_cfg_loaded == $past(cfg_loaded))
    else $error("Loaded flag does not follow capture");

  en_hold_a: assert property ( // see RL10
    !src_fall |=> $stable(en_q1) && $stable(en_q2))
    else $error("Enable stage moved without a source fall");

  zero_cascade_a: assert property ( // see RL11
    src_fall |=> en_q2 == $past(en_q1))
    else $error("Second stage missed the first stage value");

  pd_unload_a: assert property ( // see RL9
    !cfg_loaded |=> !o_global_clock_net && !o_net_active)
    else $error("Network clocked before configuration load");

  ref_fixed_a: assert property ( // see RL12
    (!i_manual_switch_en && !cfg_q.clkswitch) |=> o_pll_reference == $past(flt.clk_pin[0]))
    else $error("Static reference select not honoured");

  pll_a_pick_a: assert property ( // see RL15
    (is_dynamic && i_clk_select == gccb_pkg::SEL_PLL_A && cfg_q.pll_pick_a == 3'h0) |->
      src_sel == flt.pll_count[0])
    else $error("First PLL pick routed the wrong output");

  pll_b_pick_a: assert property ( // see RL15
    (is_dynamic && i_clk_select == gccb_pkg::SEL_PLL_B && cfg_q.pll_pick_b == 3'h1) |->
      src_sel == flt.pll_count[1])
    else $error("Second PLL pick routed the wrong output");

  dual_src_a: assert property ( // see RL4
    (cfg_loaded && cfg_q.static_src == gccb_pkg::SRC_DUAL_PURPOSE) |-> src_sel == flt.dual_pin)
    else $error("Dual-purpose source not selected");

  corner_src_a: assert property ( // see RL16
    (cfg_loaded && cfg_q.static_src == gccb_pkg::SRC_CORNER) |->
      src_sel == flt.corner_pin[cfg_q.corner_pick])
    else $error("Corner source not selected");

  internal_src_a: assert property ( // see RL2
    (cfg_loaded && cfg_q.static_src == gccb_pkg::SRC_INTERNAL) |-> src_sel == i_internal_logic)
    else $error("Internal source not selected");

  gate_off_c: cover property ($fell(en_eff) ##[1:50] src_sel);
  gate_on_c: cover property ($rose(en_eff) ##[1:50] $rose(o_global_clock_net));
  zero_path_c: cover property (cfg_q.out_zero_path && $rose(en_q2));
  manual_sw_c: cover property (i_manual_switch_en && $changed(switch_sel));
  long_off_c: cover property (off_cnt == 8'h20);

endmodule

// *** test/gccb_src_model.sv ***
`timescale 1ns/1ps
module gccb_src_model (
  // Clock
  input wire logic i_core_clk,
  // Candidate sources
  output gccb_pkg::gccb_pins_s o_pins
);
  logic [7:0] tick = 8'h00;

  // ----------------------------------------------------------------
  // Free-running sources, changed just after the edge
  // ----------------------------------------------------------------
  always @(posedge i_core_clk) begin
    tick <= #1 tick + 8'h01;
  end

  // Five PLL outputs, pins and corner pins distinct waves, except corner pin 0 equals the dual-purpose pin
  always_comb begin
    o_pins.clk_pin = tick[3:2];
    o_pins.pll_count = ~tick[6:2];
    o_pins.dual_pin = tick[4];
    o_pins.corner_pin = tick[5:4];
  end
endmodule

// *** test/tb_global_clock_control_block.sv ***
`timescale 1ns/1ps
module tb_global_clock_control_block;
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic en = 1'b0;
  logic msw_en = 1'b0;
  logic msw = 1'b0;
  logic [1:0] sel = 2'h0;
  gccb_pkg::gccb_cfg_s cfg = gccb_pkg::CFG_RESET;
  gccb_pkg::gccb_pins_s pins;
  gccb_pkg::gccb_pins_s hist [0:4];
  logic [2:0] icnt = 3'h0;
  logic ilast = 1'b0;
  logic net, act, ref_ok, pref, loaded;
  int err_total = 0;
  int n_tests = 0;

  always #5 i_core_clk = ~i_core_clk;

  // Pin history, as sampled by the design
  always @(posedge i_core_clk) begin
    hist[0] <= pins;
    hist[1] <= hist[0];
    hist[2] <= hist[1];
    hist[3] <= hist[2];
    hist[4] <= hist[3];
    ilast <= icnt[2];
    icnt <= #1 icnt + 3'h1;
  end

  gccb_src_model i_src (.i_core_clk(i_core_clk), .o_pins(pins));

  gccb_clock_ctrl i_dut (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_pins(pins), .i_internal_logic(icnt[2]),
    .i_cfg(cfg), .i_clk_select(sel), .i_net_enable(en), .i_manual_switch_en(msw_en),
    .i_manual_switch(msw), .o_global_clock_net(net), .o_net_active(act),
    .o_pll_ref_allowed(ref_ok), .o_pll_reference(pref), .o_cfg_loaded(loaded)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic pick(input gccb_pkg::gccb_pins_s p, input logic [2:0] s);
    logic [6:0] v;
    v = {p.corner_pin[1], p.corner_pin[0], p.dual_pin, p.pll_count[1], p.pll_count[0],
         p.clk_pin[1], p.clk_pin[0]};
    return v[s];
  endfunction

  task automatic chk(input string name, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic do_reset(input gccb_pkg::gccb_cfg_s c);
    i_rst_b = 1'b0;
    cfg = c;
    step(12);
    i_rst_b = 1'b1;
    step(1);
    chk("cfg_loaded", 1'b0, loaded);
    step(1);
    chk("cfg_loaded", 1'b1, loaded);
  endtask

  task automatic follow(input string name, input logic [2:0] s, input int n);
    repeat (n) begin
      step(1);
      chk(name, pick(hist[4], s), net);
    end
  endtask

  task automatic stay_low(input int n);
    repeat (n) begin
      step(1);
      chk("net_low", 1'b0, net);
    end
    chk("net_active", 1'b0, act);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_dynamic(input gccb_pkg::gccb_cfg_s c);
    do_reset(c);
    for (int s = 0; s < 4; s++) begin
      en = 1'b0;
      step(40);
      sel = 2'(s);
      step(8);
      en = 1'b1;
      step(40);
      follow("net_sel", 3'(s), 32);
      chk("ref_allowed", 1'b1, ref_ok);
    end
  endtask

  task automatic t_gate();
    sel = gccb_pkg::SEL_PIN0;
    en = 1'b0;
    step(40);
    stay_low(32);
    en = 1'b1;
    step(20);
    follow("net_resume", 3'h0, 32);
    chk("net_active", 1'b1, act);
  endtask

  task automatic t_pll_ref();
    for (int m = 0; m < 3; m++) begin
      msw_en = (m < 2);
      msw = m[0];
      step(8);
      repeat (16) begin
        step(1);
        chk("pll_reference", pick(hist[4], 3'(m[0])), pref);
      end
    end
  endtask

  task automatic t_static(input gccb_pkg::gccb_cfg_s c, input gccb_pkg::gccb_static_src_e src,
                          input logic [2:0] idx);
    c.static_src = src;
    c.corner_pick = 1'b1;
    do_reset(c);
    for (int s = 0; s < 4; s++) begin
      sel = 2'(s);
      step(40);
      repeat (16) begin
        step(1);
        if (src == gccb_pkg::SRC_INTERNAL) begin
          chk("net_internal", ilast, net);
        end else begin
          chk("net_static", pick(hist[4], idx), net);
        end
      end
      chk("ref_allowed", 1'b0, ref_ok);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    gccb_pkg::gccb_cfg_s c;
    c = gccb_pkg::CFG_RESET;
    c.power_down = 1'b0;
    t_dynamic(c);
    t_gate();
    t_pll_ref();
    c.out_zero_path = 1'b1;
    do_reset(c);
    t_gate();
    c.out_zero_path = 1'b0;
    t_static(c, gccb_pkg::SRC_DUAL_PURPOSE, 3'h4);
    t_static(c, gccb_pkg::SRC_CORNER, 3'h6);
    t_static(c, gccb_pkg::SRC_INTERNAL, 3'h0);
    c.power_down = 1'b1;
    do_reset(c);
    step(40);
    stay_low(32);
    close_out();
  end
endmodule
